// ---- inc/limit_alert_pkg.sv ----
// Package for the limit status and alert logic.
// Assumes a single 40 MHz clock domain and 16-bit registers.
package limit_alert_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0]  OFS_CONFIG      = 8'h00;
   localparam logic [7:0]  OFS_FLAGS       = 8'h01;
   localparam logic [7:0]  OFS_MASK        = 8'h02;
   localparam logic [7:0]  OFS_SHUNT       = 8'h03;
   localparam logic [15:0] RST_FLAGS       = 16'h0000;
   localparam logic [15:0] RST_MASK        = 16'h0000;
   localparam logic [15:0] RST_SHUNT       = 16'h0000;
   localparam logic [1:0]  RST_GAIN        = 2'h3;

   // ****************************************
   // Field layout
   // ****************************************
   localparam int          GAIN_LSB        = 11;
   localparam int          BIT_WARN_BUS_HI = 15;
   localparam int          BIT_WARN_BUS_LO = 14;
   localparam int          BIT_WARN_POWER  = 13;
   localparam int          BIT_WARN_SH_POS = 12;
   localparam int          BIT_WARN_SH_NEG = 11;
   localparam int          BIT_LIM_BUS_HI  = 10;
   localparam int          BIT_LIM_BUS_LO  = 9;
   localparam int          BIT_LIM_POWER   = 8;
   localparam int          BIT_FAST_POS    = 7;
   localparam int          BIT_FAST_NEG    = 6;
   localparam int          BIT_CONV_DONE   = 5;
   localparam int          BIT_ALERT       = 4;
   localparam int          BIT_OVERRUN     = 3;
   localparam int          BIT_ALERT_EN    = 3;
   localparam int          BIT_FAST_PIN_EN = 2;
   localparam int          BIT_LIM_PIN_EN  = 1;
   localparam int          BIT_WARN_PIN_EN = 0;
   // Writable mask bits: 15..5 and 3..0
   localparam logic [15:0] MASK_WR_BITS    = 16'hFFEF;
   // Flags that the mask can pass to the alert line
   localparam logic [15:0] MASK_PASS_BITS  = 16'hFFE0;
   // Flags that are implemented at all
   localparam logic [15:0] FLAG_BITS       = 16'hFFF8;

   typedef enum logic [1:0] {
      GAIN_DIV1 = 2'b00,
      GAIN_DIV2 = 2'b01,
      GAIN_DIV4 = 2'b10,
      GAIN_DIV8 = 2'b11
   } gain_e;

   // Register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } reg_req_s;

   // Latch enables per comparator group
   typedef struct packed {
      logic warn;
      logic limit;
      logic fast;
   } latch_en_s;

endpackage

// ---- core/shunt_format.sv ----
// Sign-extended shunt result formatter.
// Assumes a raw signed reading in 10 uV steps, clamped by gain range.
`timescale 1ns/1ps
module shunt_format
   import limit_alert_pkg::*;
(
   // Inputs
   input  wire logic [15:0] raw_reading,
   input  wire gain_e       gain,
   // Output
   output logic [15:0]      formatted
);

   logic signed [15:0] raw_s;
   logic signed [15:0] lim;

   assign raw_s = raw_reading;

   // Clamp to range; sign fills the upper bits by two's complement [R21] [R22]
   always_comb begin
      unique case (gain)
         GAIN_DIV1: lim = 16'sh0FA0;
         GAIN_DIV2: lim = 16'sh1F40;
         GAIN_DIV4: lim = 16'sh3E80;
         GAIN_DIV8: lim = 16'sh7D00;
      endcase
      if (raw_s > lim) begin
         formatted = lim;
      end else if (raw_s < -lim) begin
         formatted = -lim;
      end else begin
         formatted = raw_s;
      end
   end

endmodule

// ---- core/limit_status_alert_logic.sv ----
// Status flags, alert mask and pin enables of the monitor.
// Assumes comparator levels arrive synchronous to clk, one cycle per result.
//
// Functional notes
// R1: Flags set on limit violation; latched while the group's latch enable is set.
// R2: Reading status clears flags; a still-violated limit sets again at once.
// R3: Host should read status once after setup to drop stale flags.
// R4: Bit 15 set when bus voltage above bus high warning.
// R5: Bit 14 set when bus voltage below bus low warning.
// R6: Bit 13 set when power above power warning.
// R7: Bit 12 set when shunt above positive shunt warning.
// R8: Bit 11 set when shunt below negative shunt warning.
// R9: Bit 10 set when bus voltage above bus high limit.
// R10: Bit 9 set when bus voltage below bus low limit.
// R11: Bit 8 set when power above power limit.
// R12: Bit 7 set when shunt above positive fast comparator limit.
// R13: Bit 6 set when shunt below negative fast comparator limit.
// R14: Bits 5, 4, 3 report conversion done, alert, math overrun.
// R15: Mask bits 15..5 gate only alert, never flag setting.
// R16: Mask zero blocks, one passes; mask resets to zero.
// R17: Mask bit 3 globally enables alert output, reset zero.
// R18: Mask bit 2 enables critical pin, reset disabled.
// R19: Mask bit 1 enables over-limit pin, reset disabled.
// R20: Mask bit 0 enables warning pin, reset disabled.
// R21: Shunt register holds latest reading positioned by gain, sign bits equal.
// R22: Negative shunt in two's complement, sign extended to 16 bits.
// R23: Two-bit gain field selects range, widest by default.
// R24: Alert asserted while enabled and any passed flag is set.
// R25: Status bits 2..0 and mask bit 4 read zero, ignore writes.
`timescale 1ns/1ps
module limit_status_alert_logic
   import limit_alert_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Register port
   input  wire reg_req_s    req,
   output logic [15:0]      rdata_q,
   output logic             rvalid_q,
   // Latch enables from the threshold registers
   input  wire latch_en_s   latch_en,
   // Comparator results
   input  wire logic        bus_above_warn,
   input  wire logic        bus_below_warn,
   input  wire logic        power_above_warn,
   input  wire logic        shunt_above_warn,
   input  wire logic        shunt_below_warn,
   input  wire logic        bus_above_limit,
   input  wire logic        bus_below_limit,
   input  wire logic        power_above_limit,
   input  wire logic        shunt_above_fast,
   input  wire logic        shunt_below_fast,
   input  wire logic        conversion_done,
   input  wire logic        math_overrun,
   // Shunt result
   input  wire logic        shunt_valid,
   input  wire logic [15:0] shunt_raw,
   // Outputs
   output logic             alert_n_q,
   output logic             warn_pin_q,
   output logic             limit_pin_q,
   output logic             fast_pin_q,
   output logic [1:0]       shunt_gain_select_q
);

   // ****************************************
   // Flag sources
   // ****************************************
   logic [15:0] cond;
   logic [15:0] latch_bits;
   logic [15:0] flags_q;
   logic [15:0] flags_d;
   logic [15:0] mask_q;
   logic [15:0] shunt_q;
   logic [15:0] shunt_fmt;
   logic        alert_now;
   logic        rd_flags;

   always_comb begin
      cond = 16'h0000;
      cond[BIT_WARN_BUS_HI] = bus_above_warn;    // [R4]
      cond[BIT_WARN_BUS_LO] = bus_below_warn;    // [R5]
      cond[BIT_WARN_POWER]  = power_above_warn;  // [R6]
      cond[BIT_WARN_SH_POS] = shunt_above_warn;  // [R7]
      cond[BIT_WARN_SH_NEG] = shunt_below_warn;  // [R8]
      cond[BIT_LIM_BUS_HI]  = bus_above_limit;   // [R9]
      cond[BIT_LIM_BUS_LO]  = bus_below_limit;   // [R10]
      cond[BIT_LIM_POWER]   = power_above_limit; // [R11]
      cond[BIT_FAST_POS]    = shunt_above_fast;  // [R12]
      cond[BIT_FAST_NEG]    = shunt_below_fast;  // [R13]
      cond[BIT_CONV_DONE]   = conversion_done;   // [R14]
      cond[BIT_ALERT]       = alert_now;         // [R14]
      cond[BIT_OVERRUN]     = math_overrun;      // [R14]
   end

   // Latch groups: warnings, over-limits, fast comparators; events always stick
   always_comb begin
      latch_bits = 16'h0038;
      latch_bits[15:11] = {5{latch_en.warn}};
      latch_bits[10:8]  = {3{latch_en.limit}};
      latch_bits[7:6]   = {2{latch_en.fast}};
   end

   assign rd_flags = req.rd && (req.addr == OFS_FLAGS);

   // Mask bits 15..5 gate only the alert, flags themselves always set [R15] [R16] [R24]
   assign alert_now = mask_q[BIT_ALERT_EN] && |(flags_q & mask_q & MASK_PASS_BITS);

   // ****************************************
   // Status flags
   // ****************************************
   // Live condition always wins over the clearing read, so nothing is lost
   always_comb begin
      flags_d = rd_flags ? 16'h0000 : (flags_q & latch_bits);  // [R2]
      flags_d = (flags_d | cond) & FLAG_BITS;                   // [R1] [R25]
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= RST_FLAGS;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ****************************************
   // Mask and configuration
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= RST_MASK;  // [R16] [R17]
      end else if (req.wr && req.addr == OFS_MASK) begin
         mask_q <= req.wdata & MASK_WR_BITS;  // [R25]
      end
   end

   // Only the gain field of the configuration word is held here
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shunt_gain_select_q <= RST_GAIN;  // [R23]
      end else if (req.wr && req.addr == OFS_CONFIG) begin
         shunt_gain_select_q <= req.wdata[GAIN_LSB +: 2];  // [R23]
      end
   end

   // ****************************************
   // Shunt result
   // ****************************************
   shunt_format u_fmt (
      .raw_reading (shunt_raw),
      .gain        (gain_e'(shunt_gain_select_q)),
      .formatted   (shunt_fmt)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shunt_q <= RST_SHUNT;
      end else if (shunt_valid) begin
         shunt_q <= shunt_fmt;  // [R21] [R22]
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q  <= 16'h0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
         if (req.rd) begin
            unique case (req.addr)
               OFS_CONFIG: rdata_q <= {3'h0, shunt_gain_select_q, 11'h000};
               OFS_FLAGS:  rdata_q <= flags_q;
               OFS_MASK:   rdata_q <= mask_q;
               OFS_SHUNT:  rdata_q <= shunt_q;
               default:    rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   // ****************************************
   // Pins
   // ****************************************
   // Pins follow the registered flags so a latched flag keeps its pin asserted
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_n_q   <= 1'b1;
         warn_pin_q  <= 1'b0;
         limit_pin_q <= 1'b0;
         fast_pin_q  <= 1'b0;
      end else begin
         alert_n_q   <= !alert_now;                                       // [R24] [R17]
         warn_pin_q  <= mask_q[BIT_WARN_PIN_EN] && |flags_q[15:11];      // [R20]
         limit_pin_q <= mask_q[BIT_LIM_PIN_EN] && |flags_q[10:8];        // [R19]
         fast_pin_q  <= mask_q[BIT_FAST_PIN_EN] && |flags_q[7:6];        // [R18]
      end
   end

endmodule

// ---- tb/limit_status_monitor.sv ----
// Checker for the status, mask and alert block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module limit_status_monitor
   import limit_alert_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Register port
   input wire reg_req_s    req,
   input wire logic [15:0] rdata_q,
   input wire logic        rvalid_q,
   // Conditions and outputs
   input wire latch_en_s   latch_en,
   input wire logic        bus_above_warn,
   input wire logic        shunt_above_fast,
   input wire logic        shunt_below_fast,
   input wire logic        fast_pin_q,
   input wire logic [1:0]  shunt_gain_select_q
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire logic st_rd = req.rd && req.addr == OFS_FLAGS;

   read_answer_a: assert property ($past(reset_n) |-> rvalid_q == $past(req.rd))
      else $error("read answer missing or extra");
   warn_bus_flag_a: assert property (st_rd && !$past(latch_en.warn) && $past(reset_n)
      |=> rdata_q[BIT_WARN_BUS_HI] == $past(bus_above_warn, 2)) else $error("bus high warn flag wrong");
   fast_pos_flag_a: assert property (st_rd && !$past(latch_en.fast) && $past(reset_n)
      |=> rdata_q[BIT_FAST_POS] == $past(shunt_above_fast, 2)) else $error("fast positive flag wrong");
   fast_pin_idle_a: assert property ((!latch_en.fast && !shunt_above_fast && !shunt_below_fast)[*2]
      |=> !fast_pin_q) else $error("fast pin high without cause");
   gain_hold_a: assert property (!(req.wr && req.addr == OFS_CONFIG) |=> $stable(shunt_gain_select_q))
      else $error("gain changed without write");
   gain_load_a: assert property (req.wr && req.addr == OFS_CONFIG
      |=> shunt_gain_select_q == $past(req.wdata[12:11])) else $error("gain not loaded");
   rdata_hold_a: assert property (!req.rd |=> $stable(rdata_q))
      else $error("read data moved without read");
   status_low_a: assert property (st_rd |=> rdata_q[2:0] == 3'h0)
      else $error("unused status bits set");
   unmapped_zero_a: assert property (req.rd && req.addr > OFS_SHUNT |=> rdata_q == 16'h0000)
      else $error("unmapped read not zero");
endmodule

bind limit_status_alert_logic limit_status_monitor i_mon (.clk(clk), .reset_n(reset_n), .req(req),
   .rdata_q(rdata_q), .rvalid_q(rvalid_q), .latch_en(latch_en), .bus_above_warn(bus_above_warn),
   .shunt_above_fast(shunt_above_fast), .shunt_below_fast(shunt_below_fast), .fast_pin_q(fast_pin_q),
   .shunt_gain_select_q(shunt_gain_select_q));

// ---- tb/reg_host_model.sv ----
// Host model on the register port of the status block.
// Assumes requests launch at a rising edge and answers come one cycle later.
`timescale 1ns/1ps
module reg_host_model
   import limit_alert_pkg::*;
(
   // Register port
   input  wire logic        clk,
   output reg_req_s         req,
   input  wire logic [15:0] rdata_q,
   input  wire logic        rvalid_q
);
   initial req = '0;
   // Strobes drop at the taking edge, so the next call starts a cycle later
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      #1;
      d = rvalid_q ? rdata_q : 16'hXXXX;
   endtask
endmodule

// ---- tb/limit_status_alert_logic_tb_top.sv ----
// Testbench for the status, mask and alert block.
// Assumes the host model owns the register port; the bench drives all else.
`timescale 1ns/1ps
module limit_status_alert_logic_tb_top import limit_alert_pkg::*;;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        shunt_valid = 1'b0;
   logic [15:0] cond = '0;
   logic [15:0] shunt_raw = '0;
   logic [15:0] got, lim;
   latch_en_s   latch_en = '0;
   reg_req_s    req;
   logic [15:0] rdata_q;
   logic        rvalid_q, alert_n_q, warn_pin_q, limit_pin_q, fast_pin_q;
   logic [1:0]  gain;
   int          errors = 0, compares = 0, cycles = 0;
   always #12.5 clk = ~clk;

   reg_host_model i_host (.clk(clk), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q));
   limit_status_alert_logic i_dut (.clk(clk), .reset_n(reset_n), .req(req), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .latch_en(latch_en), .bus_above_warn(cond[15]), .bus_below_warn(cond[14]),
      .power_above_warn(cond[13]), .shunt_above_warn(cond[12]), .shunt_below_warn(cond[11]),
      .bus_above_limit(cond[10]), .bus_below_limit(cond[9]), .power_above_limit(cond[8]),
      .shunt_above_fast(cond[7]), .shunt_below_fast(cond[6]), .conversion_done(cond[5]),
      .math_overrun(cond[3]), .shunt_valid(shunt_valid), .shunt_raw(shunt_raw), .alert_n_q(alert_n_q),
      .warn_pin_q(warn_pin_q), .limit_pin_q(limit_pin_q), .fast_pin_q(fast_pin_q),
      .shunt_gain_select_q(gain));

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] e);
      i_host.rd(a, got);
      chk(got, e);
   endtask
   // Outputs as {alert_n, warn, limit, fast}, two edges after the cause
   task automatic pins(input logic [15:0] e);
      repeat (2) @(posedge clk);
      #1 chk({12'h000, alert_n_q, warn_pin_q, limit_pin_q, fast_pin_q}, e);
   endtask
   task automatic pulse(input logic [15:0] v);
      @(posedge clk) cond <= v;
      @(posedge clk) cond <= '0;
      repeat (2) @(posedge clk);
   endtask
   task automatic shv(input logic [15:0] raw, input logic [15:0] e);
      @(posedge clk) begin
         shunt_raw <= raw;
         shunt_valid <= 1'b1;
      end
      @(posedge clk) shunt_valid <= 1'b0;
      rchk(OFS_SHUNT, e);
   endtask
   task automatic final_report;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard: the tests need well under a thousand cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         errors++;
         final_report;
      end
   end

   // ********
   // Tests
   // ********
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rchk(OFS_FLAGS, 16'h0000);
      rchk(OFS_MASK, 16'h0000);
      rchk(OFS_CONFIG, 16'h1800);
      pins(16'h0008);
      $display("test reset done");
      for (int i = 6; i < 16; i++) begin
         @(posedge clk) cond <= 16'h0001 << i;
         repeat (2) @(posedge clk);
         rchk(OFS_FLAGS, 16'h0001 << i);
      end
      rchk(OFS_FLAGS, 16'h8000);
      @(posedge clk) cond <= '0;
      repeat (2) @(posedge clk);
      rchk(OFS_FLAGS, 16'h0000);
      pulse(16'h0028);
      rchk(OFS_FLAGS, 16'h0028);
      rchk(OFS_FLAGS, 16'h0000);
      @(posedge clk) latch_en <= '1;
      pulse(16'hFFC0);
      rchk(OFS_FLAGS, 16'hFFC0);
      rchk(OFS_FLAGS, 16'h0000);
      @(posedge clk) latch_en <= '0;
      $display("test flags done");
      i_host.wr(OFS_MASK, 16'hFFFF);
      rchk(OFS_MASK, 16'hFFEF);
      @(posedge clk) cond <= 16'h8480;
      pins(16'h0007);
      rchk(OFS_FLAGS, 16'h8490);
      i_host.wr(OFS_MASK, 16'h000F);
      pins(16'h000F);
      // Alert flag is sticky: set again by the last read, it stays until the next one
      rchk(OFS_FLAGS, 16'h8490);
      rchk(OFS_FLAGS, 16'h8480);
      i_host.wr(OFS_MASK, 16'hFFE8);
      pins(16'h0000);
      i_host.wr(OFS_MASK, 16'hFFE0);
      pins(16'h0008);
      @(posedge clk) cond <= '0;
      i_host.wr(OFS_MASK, 16'h0000);
      rchk(OFS_FLAGS, 16'h0010);
      rchk(OFS_FLAGS, 16'h0000);
      $display("test mask done");
      for (int g = 0; g < 4; g++) begin
         lim = 16'(4000 << g);
         i_host.wr(OFS_CONFIG, 16'(g << 11));
         rchk(OFS_CONFIG, 16'(g << 11));
         chk({14'h0, gain}, 16'(g));
         shv(16'h82FF, ~lim + 16'h0001);
         shv(16'h7D02, lim);
         shv(16'hFFFE, 16'hFFFE);
      end
      i_host.wr(OFS_SHUNT, 16'h1234);
      i_host.wr(OFS_FLAGS, 16'hFFFF);
      rchk(OFS_SHUNT, 16'hFFFE);
      rchk(OFS_FLAGS, 16'h0000);
      rchk(8'h40, 16'h0000);
      $display("test shunt done");
      final_report;
   end
endmodule
